// file: core/qvss_pkg.sv
package qvss_pkg;

  // clock and timing
  localparam longint QVSS_CLK_HZ = 40_000_000;
  localparam int QVSS_EVAL_PERIOD_MS = 48;
  localparam int QVSS_EVAL_CYC =
    int'((longint'(QVSS_EVAL_PERIOD_MS) * QVSS_CLK_HZ) / 1000);
  localparam int QVSS_SS_TOTAL_MS = 12;
  localparam int QVSS_SS_STEPS = 4;
  localparam int QVSS_SS_STEP_CYC = int'((longint'(QVSS_SS_TOTAL_MS) *
    QVSS_CLK_HZ) / (1000 * longint'(QVSS_SS_STEPS)));
  // longest off time, rounded down
  localparam int QVSS_OFFMAX_NS = 50000;
  localparam int QVSS_OFFMAX_CYC =
    int'((longint'(QVSS_OFFMAX_NS) * QVSS_CLK_HZ) / 1_000_000_000);
  // ringing suppression, least times, rounded up
  localparam int QVSS_RS_LONG_NS = 2500;
  localparam int QVSS_RS_SHORT_NS = 750;
  localparam int QVSS_RS_LONG_CYC = int'((longint'(QVSS_RS_LONG_NS) *
    QVSS_CLK_HZ + 999_999_999) / 1_000_000_000);
  localparam int QVSS_RS_SHORT_CYC = int'((longint'(QVSS_RS_SHORT_NS) *
    QVSS_CLK_HZ + 999_999_999) / 1_000_000_000);

  // valley-skip counter
  localparam logic [2:0] QVSS_VSC_MIN = 3'h1;
  localparam logic [2:0] QVSS_VSC_MAX = 3'h7;
  localparam logic [2:0] QVSS_VSC_RESET = 3'h1;
  localparam logic [2:0] QVSS_XING_MAX = 3'h7;

  // current-sense limit in mV per soft-start step
  localparam logic [9:0] QVSS_LIM_STEP0 = 10'h140;
  localparam logic [9:0] QVSS_LIM_STEP1 = 10'h222;
  localparam logic [9:0] QVSS_LIM_STEP2 = 10'h305;
  localparam logic [9:0] QVSS_LIM_FINAL = 10'h3E8;
  localparam logic [1:0] QVSS_SS_LAST = 2'h3;

  // register map (byte addresses)
  localparam logic [7:0] QVSS_CTRL_OFS = 8'h00;
  localparam logic [7:0] QVSS_STATUS_OFS = 8'h04;
  localparam logic [7:0] QVSS_ZONE_OFS = 8'h08;
  localparam int QVSS_CTRL_EN_BIT = 0;
  localparam logic QVSS_CTRL_EN_RST = 1'b1;
  localparam int QVSS_ST_VSC_LSB = 0;
  localparam int QVSS_ST_XING_LSB = 4;
  localparam int QVSS_ST_SS_LSB = 8;
  localparam int QVSS_ST_SSDONE_BIT = 12;
  localparam int QVSS_ST_RUN_BIT = 13;
  localparam int QVSS_ST_GATE_BIT = 14;
  localparam int QVSS_ST_LINE_BIT = 15;
  localparam logic [1:0] QVSS_RESP_OKAY = 2'h0;
  localparam logic [1:0] QVSS_RESP_SLVERR = 2'h2;

  // analog comparator inputs, all asynchronous
  typedef struct packed {
    logic zero_crossing_input; // zero-crossing comparator
    logic supply_on;    // supply above turn-on threshold
    logic trip;         // current comparison ends the on time
    logic line_high;    // high line detected
    logic xing_above_rs; // crossing input above ringing-suppression level
    logic zl_lo_line;   // feedback above zone low, low-line set
    logic zl_hi_line;   // feedback above zone low, high-line set
    logic zh_lo_line;   // feedback above zone high, low-line set
    logic zh_hi_line;   // feedback above zone high, high-line set
    logic fbk_reset;    // feedback above counter reset threshold
  } qvss_ana_t;

  typedef enum logic [2:0] {
    GS_RING = 3'b001,
    GS_WAIT = 3'b010,
    GS_ON = 3'b100
  } qvss_gs_t;

  typedef struct packed {
    qvss_ana_t s1;
    qvss_ana_t s2;
    qvss_ana_t s3;
    qvss_ana_t filt;
    logic run;
    logic [20:0] eval_cnt;
    logic ever_zl;
    logic ever_zh;
    logic ever_r;
    logic [2:0] vsc;
    logic [2:0] xing;
    qvss_gs_t gs;
    logic [10:0] off_cnt;
    logic [6:0] rs_cnt;
    logic [16:0] ss_cnt;
    logic [1:0] ss_step;
    logic ss_done;
    logic [9:0] lim;
    logic ctrl_en;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } qvss_st_t;

endpackage : qvss_pkg

// file: core/qvss_ctrl.sv
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module qvss_ctrl
  import qvss_pkg::*;
#(
  parameter int EVAL_CYCLES = QVSS_EVAL_CYC,
  parameter int SS_STEP_CYCLES = QVSS_SS_STEP_CYC
) (
  input wire logic CLOCK,               // 40 MHz clock
  input wire logic RST_B,               // async reset, active low
  input wire qvss_ana_t ANALOG_IN,      // comparator outputs
  output logic GATE_DRIVE,              // power switch gate
  output logic STARTUP_CELL_EN,         // startup charging cell on
  output logic [9:0] CS_LIMIT_MV,       // peak current-sense limit, mV
  output logic SOFT_START_DONE,         // soft-start finished
  output logic ZONE_SET_HIGH_LINE,      // high-line zone thresholds used
  output logic [2:0] VALLEY_SKIP,       // valley-skip counter
  input wire logic [31:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID,       // write address valid
  output logic S_AXI_AWREADY,           // write address ready
  input wire logic [31:0] S_AXI_WDATA,  // write data
  input wire logic [3:0] S_AXI_WSTRB,   // write strobes
  input wire logic S_AXI_WVALID,        // write data valid
  output logic S_AXI_WREADY,            // write data ready
  output logic [1:0] S_AXI_BRESP,       // write response
  output logic S_AXI_BVALID,            // write response valid
  input wire logic S_AXI_BREADY,        // write response ready
  input wire logic [31:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID,       // read address valid
  output logic S_AXI_ARREADY,           // read address ready
  output logic [31:0] S_AXI_RDATA,      // read data
  output logic [1:0] S_AXI_RRESP,       // read response
  output logic S_AXI_RVALID,            // read data valid
  input wire logic S_AXI_RREADY         // read data ready
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction : hit

  function automatic logic [9:0] lim_of(input logic [1:0] step);
    logic [9:0] v;
    v = QVSS_LIM_STEP0;
    if (step == 2'h1) begin
      v = QVSS_LIM_STEP1;
    end else if (step == 2'h2) begin
      v = QVSS_LIM_STEP2;
    end else if (step == QVSS_SS_LAST) begin
      v = QVSS_LIM_FINAL;
    end
    lim_of = v;
  endfunction : lim_of

  localparam logic [20:0] EVAL_LAST = 21'(EVAL_CYCLES - 1);
  localparam logic [16:0] SS_LAST_CNT = 17'(SS_STEP_CYCLES - 1);
  localparam logic [10:0] OFF_LAST = 11'(QVSS_OFFMAX_CYC - 1);
  localparam logic [6:0] RS_LONG = 7'(QVSS_RS_LONG_CYC - 1);
  localparam logic [6:0] RS_SHORT = 7'(QVSS_RS_SHORT_CYC - 1);

  qvss_st_t r_reg;
  qvss_st_t r_next;

  logic active;
  logic zl_now;
  logic zh_now;
  logic xing_fall;
  logic ev_zl;
  logic ev_zh;
  logic ev_r;
  logic eval_tick;
  logic offmax_hit;
  logic can_on;
  logic wr_go;
  logic [31:0] status_word;

  ////////////////////////////////////////////////////////////////////////
  // combinational next state

  always_comb begin
    r_next = r_reg;
    // filtered level changes once the last two stages agree
    r_next.s1 = ANALOG_IN;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.filt = (~(r_reg.s2 ^ r_reg.s3) & r_reg.s3) |
                  ((r_reg.s2 ^ r_reg.s3) & r_reg.filt);

    active = r_reg.run & r_reg.ctrl_en;
    // thresholds follow line level so foldback leaves them alone
    zl_now = r_reg.filt.line_high ? r_reg.filt.zl_hi_line
                                  : r_reg.filt.zl_lo_line;
    zh_now = r_reg.filt.line_high ? r_reg.filt.zh_hi_line
                                  : r_reg.filt.zh_lo_line;
    xing_fall = r_reg.filt.zero_crossing_input &
                ~r_reg.s2.zero_crossing_input & ~r_reg.s3.zero_crossing_input;
    // sample of the boundary cycle itself still counts
    ev_zl = r_reg.ever_zl | zl_now;
    ev_zh = r_reg.ever_zh | zh_now;
    ev_r = r_reg.ever_r | r_reg.filt.fbk_reset;
    eval_tick = r_reg.run && (r_reg.eval_cnt == EVAL_LAST);
    offmax_hit = (r_reg.off_cnt == OFF_LAST);
    can_on = 1'b0;

    // supply on with the enable bit set starts operation; loss of supply stops it
    if (!r_reg.filt.supply_on) begin
      r_next.run = 1'b0;
    end else if (!r_reg.run && r_reg.ctrl_en) begin
      r_next.run = 1'b1;
      r_next.vsc = QVSS_VSC_RESET;
      r_next.eval_cnt = '0;
      r_next.ever_zl = 1'b0;
      r_next.ever_zh = 1'b0;
      r_next.ever_r = 1'b0;
      r_next.ss_cnt = '0;
      r_next.ss_step = '0;
      r_next.ss_done = 1'b0;
    end

    // evaluation period and counter action
    if (r_reg.run) begin
      if (eval_tick) begin
        r_next.eval_cnt = '0;
        r_next.ever_zl = 1'b0;
        r_next.ever_zh = 1'b0;
        r_next.ever_r = 1'b0;
        if (ev_r) begin
          r_next.vsc = QVSS_VSC_RESET;
        end else if (ev_zh) begin
          if (r_reg.vsc > QVSS_VSC_MIN) begin
            r_next.vsc = r_reg.vsc - 3'h1;
          end
        end else if (!ev_zl) begin
          if (r_reg.vsc < QVSS_VSC_MAX) begin
            r_next.vsc = r_reg.vsc + 3'h1;
          end
        end
        // only low zone crossed: value held
      end else begin
        r_next.eval_cnt = r_reg.eval_cnt + 21'h1;
        r_next.ever_zl = ev_zl;
        r_next.ever_zh = ev_zh;
        r_next.ever_r = ev_r;
      end
    end

    // soft-start: four equal steps, limit rises each step
    if (r_reg.run && !r_reg.ss_done) begin
      if (r_reg.ss_cnt == SS_LAST_CNT) begin
        r_next.ss_cnt = '0;
        if (r_reg.ss_step == QVSS_SS_LAST) begin
          r_next.ss_done = 1'b1;
        end else begin
          r_next.ss_step = r_reg.ss_step + 2'h1;
        end
      end else begin
        r_next.ss_cnt = r_reg.ss_cnt + 17'h1;
      end
    end
    r_next.lim = lim_of(r_next.ss_step);

    // switching: on is digital, off comes from the analog trip or from operation no longer active
    case (r_reg.gs)
      GS_ON: begin
        if (r_reg.filt.trip || !active) begin
          r_next.gs = GS_RING;
          r_next.off_cnt = '0;
          r_next.rs_cnt = r_reg.filt.xing_above_rs ? RS_SHORT : RS_LONG;
        end
      end
      GS_RING: begin
        // gate may not rise while the drain still rings
        if (r_reg.rs_cnt == 7'h0) begin
          r_next.gs = GS_WAIT;
        end else begin
          r_next.rs_cnt = r_reg.rs_cnt - 7'h1;
        end
      end
      GS_WAIT: begin
        // vsc tells at which counted valley the gate turns on
        can_on = active && ((r_reg.xing >= r_reg.vsc) ||
                            offmax_hit);
        if (can_on) begin
          r_next.gs = GS_ON;
        end
      end
      default: begin
        r_next.gs = GS_WAIT;
      end
    endcase
    if (r_reg.gs != GS_ON && !offmax_hit) begin
      r_next.off_cnt = r_reg.off_cnt + 11'h1;
    end
    if (r_reg.gs != GS_ON && xing_fall && r_reg.xing != QVSS_XING_MAX) begin
      r_next.xing = r_reg.xing + 3'h1;
    end
    if (r_next.gs == GS_ON && r_reg.gs != GS_ON) begin
      r_next.xing = '0;
    end

    // AXI4-Lite write: address and data in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      r_next.aw_got = 1'b1;
      r_next.awaddr = S_AXI_AWADDR[7:0];
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      r_next.w_got = 1'b1;
      r_next.wdata = S_AXI_WDATA;
      r_next.wstrb = S_AXI_WSTRB;
    end
    wr_go = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;
    if (wr_go) begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = QVSS_RESP_OKAY;
      if (hit(r_reg.awaddr, QVSS_CTRL_OFS)) begin
        if (r_reg.wstrb[0]) begin
          r_next.ctrl_en = r_reg.wdata[QVSS_CTRL_EN_BIT];
        end
      end else if (hit(r_reg.awaddr, QVSS_STATUS_OFS) ||
                   hit(r_reg.awaddr, QVSS_ZONE_OFS)) begin
        r_next.bresp = QVSS_RESP_OKAY;
      end else begin
        r_next.bresp = QVSS_RESP_SLVERR;
      end
    end else if (r_reg.bvalid && S_AXI_BREADY) begin
      r_next.bvalid = 1'b0;
    end

    // AXI4-Lite read
    status_word = '0;
    status_word[QVSS_ST_VSC_LSB +: 3] = r_reg.vsc;
    status_word[QVSS_ST_XING_LSB +: 3] = r_reg.xing;
    status_word[QVSS_ST_SS_LSB +: 2] = r_reg.ss_step;
    status_word[QVSS_ST_SSDONE_BIT] = r_reg.ss_done;
    status_word[QVSS_ST_RUN_BIT] = r_reg.run;
    status_word[QVSS_ST_GATE_BIT] = (r_reg.gs == GS_ON);
    status_word[QVSS_ST_LINE_BIT] = r_reg.filt.line_high;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = QVSS_RESP_OKAY;
      r_next.rdata = 32'h0000_0000;
      if (hit(S_AXI_ARADDR[7:0], QVSS_CTRL_OFS)) begin
        r_next.rdata[QVSS_CTRL_EN_BIT] = r_reg.ctrl_en;
      end else if (hit(S_AXI_ARADDR[7:0], QVSS_STATUS_OFS)) begin
        r_next.rdata = status_word;
      end else if (hit(S_AXI_ARADDR[7:0], QVSS_ZONE_OFS)) begin
        r_next.rdata[2:0] = {r_reg.ever_r, r_reg.ever_zh, r_reg.ever_zl};
      end else begin
        r_next.rresp = QVSS_RESP_SLVERR;
      end
    end else if (r_reg.rvalid && S_AXI_RREADY) begin
      r_next.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      r_reg <= '0;
      r_reg.vsc <= QVSS_VSC_RESET;
      r_reg.gs <= GS_WAIT;
      r_reg.lim <= QVSS_LIM_STEP0;
      r_reg.ctrl_en <= QVSS_CTRL_EN_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign GATE_DRIVE = (r_reg.gs == GS_ON);
  assign STARTUP_CELL_EN = ~r_reg.run;
  assign CS_LIMIT_MV = r_reg.lim;
  assign SOFT_START_DONE = r_reg.ss_done;
  assign ZONE_SET_HIGH_LINE = r_reg.filt.line_high;
  assign VALLEY_SKIP = r_reg.vsc;
  assign S_AXI_AWREADY = ~r_reg.aw_got & ~r_reg.bvalid;
  assign S_AXI_WREADY = ~r_reg.w_got & ~r_reg.bvalid;
  assign S_AXI_BVALID = r_reg.bvalid;
  assign S_AXI_BRESP = r_reg.bresp;
  assign S_AXI_ARREADY = ~r_reg.rvalid;
  assign S_AXI_RVALID = r_reg.rvalid;
  assign S_AXI_RDATA = r_reg.rdata;
  assign S_AXI_RRESP = r_reg.rresp;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);

  AST_VSC_RANGE: assert property (
    r_reg.vsc >= 3'h1 && r_reg.vsc <= 3'h7)
    else $error("valley-skip counter out of range");
  AST_VSC_STILL: assert property (
    !eval_tick && !(r_reg.filt.supply_on && !r_reg.run && r_reg.ctrl_en)
    |=> $stable(r_reg.vsc))
    else $error("counter moved off a period boundary");
  AST_VSC_UP: assert property (
    eval_tick && !ev_zl && !ev_zh && !ev_r && r_reg.filt.supply_on
    |=> r_reg.vsc == ($past(r_reg.vsc) == 3'h7 ? 3'h7
                      : $past(r_reg.vsc) + 3'h1))
    else $error("counter did not step up");
  AST_VSC_HOLD: assert property (
    eval_tick && ev_zl && !ev_zh && !ev_r && r_reg.filt.supply_on
    |=> $stable(r_reg.vsc))
    else $error("counter changed in middle zone");
  AST_VSC_DOWN: assert property (
    eval_tick && ev_zh && !ev_r && r_reg.filt.supply_on
    |=> r_reg.vsc == ($past(r_reg.vsc) == 3'h1 ? 3'h1
                      : $past(r_reg.vsc) - 3'h1))
    else $error("counter did not step down");
  AST_VSC_LOAD: assert property (
    eval_tick && ev_r && r_reg.filt.supply_on |=> r_reg.vsc == 3'h1)
    else $error("counter not loaded with one");
  AST_XING_CLEAR: assert property (
    $rose(GATE_DRIVE) |-> r_reg.xing == 3'h0 ##1 r_reg.xing == 3'h0)
    else $error("crossing count not cleared at gate on");
  AST_GATE_CAUSE: assert property (
    !GATE_DRIVE ##1 GATE_DRIVE |-> $past(r_reg.gs) == GS_WAIT &&
    ($past(r_reg.xing) >= $past(r_reg.vsc) ||
     $past(r_reg.off_cnt) == OFF_LAST))
    else $error("gate rose without its cause");
  AST_OFFMAX: assert property (
    r_reg.gs == GS_WAIT && r_reg.off_cnt == OFF_LAST && active
    |=> GATE_DRIVE)
    else $error("maximum off time exceeded");
  AST_STARTUP: assert property (
    $rose(r_reg.run) |-> !STARTUP_CELL_EN && r_reg.ss_step == 2'h0 &&
    !SOFT_START_DONE)
    else $error("turn-on did not start soft-start");
  AST_SS_LIMIT: assert property (
    SOFT_START_DONE && r_reg.run |->
    CS_LIMIT_MV == QVSS_LIM_FINAL ##1 CS_LIMIT_MV == QVSS_LIM_FINAL)
    else $error("final limit not one volt");

endmodule : qvss_ctrl

`default_nettype wire

// file: sim/qvss_analog_model.sv
`timescale 1ns/10ps
`default_nettype none

module qvss_analog_model
  import qvss_pkg::*;
(
  input wire logic clk,            // system clock
  input wire logic gate,           // gate drive of the power switch
  input wire logic supply_on,      // supply above turn-on threshold
  input wire logic line_high,      // high line present
  input wire logic [1:0] fbk_level, // 0 below zone low .. 3 above reset
  input wire logic ring_en,        // aux winding still rings when off
  output var qvss_ana_t ana        // comparator outputs
);
  logic [11:0] on_cnt = '0;
  logic [11:0] off_cnt = '0;

  always_ff @(posedge clk) begin
    on_cnt <= gate ? on_cnt + 12'h001 : '0;
    off_cnt <= gate ? '0 : off_cnt + 12'h001;
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    ana = '0;
    ana.supply_on = supply_on;
    ana.line_high = line_high;
    // peak current reached after 8 cycles on
    ana.trip = gate && (on_cnt >= 12'h008);
    // pin clamped low while on; a falling crossing every 60 cycles off
    ana.zero_crossing_input = ring_en && !gate &&
                              ((off_cnt % 12'h03C) >= 12'h01E);
    // thresholds differ per line, so only the selected set may trip
    ana.zl_lo_line = !line_high && (fbk_level >= 2'h1);
    ana.zh_lo_line = !line_high && (fbk_level >= 2'h2);
    ana.zl_hi_line = line_high && (fbk_level >= 2'h1);
    ana.zh_hi_line = line_high && (fbk_level >= 2'h2);
    ana.fbk_reset = (fbk_level == 2'h3);
  end
endmodule : qvss_analog_model

`default_nettype wire

// file: sim/qvss_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none

module qvss_ctrl_tb;
  import qvss_pkg::*;
  logic clock;
  logic rst_b;
  logic supply_on;
  logic line_high;
  logic ring_en;
  logic [1:0] fbk_level;
  qvss_ana_t ana;
  logic gate;
  logic cell_en;
  logic ss_done;
  logic zone_hi;
  logic [9:0] cs_lim;
  logic [2:0] vsc;
  logic [31:0] awaddr;
  logic [31:0] wdata;
  logic [31:0] araddr;
  logic [31:0] rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp;
  logic [1:0] rresp;
  int err_count;
  int comparisons;

  // short counts keep the run small
  qvss_ctrl #(.EVAL_CYCLES(64), .SS_STEP_CYCLES(32)) qvss_ctrl_i (
    .CLOCK(clock), .RST_B(rst_b), .ANALOG_IN(ana), .GATE_DRIVE(gate),
    .STARTUP_CELL_EN(cell_en), .CS_LIMIT_MV(cs_lim),
    .SOFT_START_DONE(ss_done), .ZONE_SET_HIGH_LINE(zone_hi),
    .VALLEY_SKIP(vsc), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));

  qvss_analog_model qvss_analog_model_i (
    .clk(clock), .gate(gate), .supply_on(supply_on),
    .line_high(line_high), .fbk_level(fbk_level), .ring_en(ring_en),
    .ana(ana));

  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (err_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task guard(input int n);
    if (n > 3000) begin
      err_count++;
      report_and_stop();
    end
  endtask : guard

  task axi_wr(input logic [31:0] a, input logic [31:0] d,
              output logic [1:0] r);
    int n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'h0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!tb) begin
      @(negedge clock);
      ta = awready;
      tw = wready;
      tb = bvalid;
      r = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
      n++;
      guard(n * 60);
    end
  endtask : axi_wr

  task axi_rd(input logic [31:0] a, output logic [31:0] d,
              output logic [1:0] r);
    int n;
    logic ta, tr;
    n = 0;
    tr = 1'h0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!tr) begin
      @(negedge clock);
      ta = arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ta) arvalid <= 1'h0;
      if (tr) rready <= 1'h0;
      n++;
      guard(n * 60);
    end
  endtask : axi_rd

  // waits at falling edges, so gate is settled when looked at
  task wait_gate(input logic lvl, output int n);
    n = 0;
    @(negedge clock);
    while (gate !== lvl) begin
      @(negedge clock);
      n++;
      guard(n);
    end
  endtask : wait_gate

  task t_off(input int lo, input int hi);
    int n;
    logic ok;
    wait_gate(1'h1, n);
    wait_gate(1'h0, n);
    wait_gate(1'h1, n);
    ok = (n >= lo) && (n <= hi);
    chk({31'h0, ok}, 32'h0000_0001);
  endtask : t_off

  ////////////////////////////////////////////////////////////////////////
  task t_reset_regs;
    logic [31:0] d;
    logic [1:0] r;
    @(negedge clock);
    chk({29'h0, vsc}, 32'h0000_0001);
    chk({31'h0, cell_en}, 32'h0000_0001);
    chk({22'h0, cs_lim}, {22'h0, QVSS_LIM_STEP0});
    chk({31'h0, gate}, 32'h0000_0000);
    axi_rd(32'h0000_0000, d, r);
    chk(d, 32'h0000_0001);
    axi_rd(32'h0000_000C, d, r);
    chk({r, d[29:0]}, {QVSS_RESP_SLVERR, 30'h0});
    axi_wr(32'h0000_0004, 32'hFFFF_FFFF, r);
    chk({30'h0, r}, {30'h0, QVSS_RESP_OKAY});
    axi_rd(32'h0000_0004, d, r);
    chk(d, 32'h0000_0001);
    axi_wr(32'h0000_0000, 32'h0000_0000, r);
  endtask : t_reset_regs

  task t_start;
    int n;
    logic [9:0] lims [4];
    logic [1:0] r;
    lims = '{QVSS_LIM_STEP0, QVSS_LIM_STEP1, QVSS_LIM_STEP2, QVSS_LIM_FINAL};
    @(posedge clock);
    supply_on <= 1'h1;
    repeat (20) @(posedge clock);
    @(negedge clock);
    chk({31'h0, cell_en}, 32'h0000_0001);
    axi_wr(32'h0000_0000, 32'h0000_0001, r);
    n = 0;
    while (cell_en !== 1'h0) begin
      @(negedge clock);
      n++;
      guard(n);
    end
    // sample each soft-start step in its middle
    repeat (16) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      chk({22'h0, cs_lim}, {22'h0, lims[i]});
      chk({31'h0, ss_done}, 32'h0000_0000);
      repeat (32) @(posedge clock);
    end
    @(negedge clock);
    chk({31'h0, ss_done}, 32'h0000_0001);
  endtask : t_start

  // starts half a period after the second evaluation boundary
  task t_counter;
    logic [1:0] fbs [12];
    logic [2:0] exps [12];
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
    fbs = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h2,
            2'h0, 2'h0};
    exps = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h7, 3'h7, 3'h6, 3'h5, 3'h1, 3'h1,
             3'h1, 3'h2};
    repeat (16) @(posedge clock);
    @(negedge clock);
    chk({29'h0, vsc}, 32'h0000_0003);
    for (int i = 0; i < 12; i++) begin
      @(posedge clock);
      fbk_level <= fbs[i];
      if (i == 6) line_high <= 1'h1;
      if (fbs[i] == 2'h3) begin
        repeat (8) @(posedge clock);
        axi_rd(32'h0000_0008, d, r);
        chk(d, 32'h0000_0007);
        repeat (47) @(posedge clock);
      end else
        repeat (63) @(posedge clock);
      @(negedge clock);
      d = {29'h0, vsc};
      e = {29'h0, exps[i]};
      chk(d, e);
    end
    chk({31'h0, zone_hi}, 32'h0000_0001);
    @(posedge clock);
    fbk_level <= 2'h1;
    axi_rd(32'h0000_0004, d, r);
    chk({29'h0, d[2:0]}, 32'h0000_0002);
  endtask : t_counter

  task t_gate;
    int n;
    logic [1:0] r;
    // two crossings needed, the second lands near 120 cycles off
    t_off(120, 132);
    @(posedge clock);
    fbk_level <= 2'h3;
    repeat (128) @(posedge clock);
    fbk_level <= 2'h1;
    // first crossing comes inside ringing suppression
    t_off(100, 106);
    @(posedge clock);
    ring_en <= 1'h0;
    t_off(1995, 2006);
    axi_wr(32'h0000_0000, 32'h0000_0000, r);
    repeat (2) @(posedge clock);
    n = 0;
    repeat (2100) begin
      @(negedge clock);
      if (gate !== 1'h0) n++;
    end
    chk(n, 0);
    @(posedge clock);
    supply_on <= 1'h0;
    repeat (10) @(posedge clock);
    @(negedge clock);
    chk({31'h0, cell_en}, 32'h0000_0001);
  endtask : t_gate

  ////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    comparisons = 0;
    rst_b = 1'h0;
    supply_on = 1'h0;
    line_high = 1'h0;
    ring_en = 1'h1;
    fbk_level = 2'h0;
    awaddr = '0;
    wdata = '0;
    araddr = '0;
    awvalid = 1'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    repeat (20) @(posedge clock);
    rst_b <= 1'h1;
    t_reset_regs();
    t_start();
    t_counter();
    t_gate();
    report_and_stop();
  end
endmodule : qvss_ctrl_tb

`default_nettype wire
